// File: logic/sbm_master.sv
// System bus master read port: arbitration, address phase, read data
`timescale 1ns/1ps
`include "sbm_regs.svh"
//
// Contract
// [RQ1] Grant already held when sampled: skip requests, start at once.
// [RQ2] Local bus request stays active until grant.
// [RQ3] Locked-sequence signal covers back-to-back operations of a series.
// [RQ4] Cache-block fills never raise the locked-sequence signal.
// [RQ5] All-bus request raised and held until grant arrives.
// [RQ6] Address on 31:3 (memory) or 15:2 (I/O), status on 63:32.
// [RQ7] Address strobe asserted exactly one bus clock with address.
// [RQ8] Slaves latch address using the group strobe from system logic.
// [RQ9] Mode pin sampled during reset selects bus type.
// [RQ10] Data captured the clock after acknowledge with hold negated.
// [RQ11] At least one idle clock follows each single-qword read.
// [RQ12] Slave acknowledge no earlier than second clock after group strobe.
// [RQ13] Slave acknowledge no later than third clock after group strobe.
// [RQ14] Alternate-bus interface acknowledges when nobody did by third clock.
// [RQ15] Cacheable indication raised by acknowledge, held while acknowledged.
// [RQ16] Cacheable indication dropped by end of slave data drive.
// [RQ17] Ownership indication valid whenever group acknowledge is asserted.
// [RQ18] Master leaves the address/data lines undriven in read data phase.
// [RQ19] Hold request raised when data cannot be accepted next clock; the code raises it only while group hold is already up with group acknowledge.
// [RQ20] Slave drops acknowledge after one good clock, data one later.
// [RQ21] All handshakes synchronous to rising bus clock edges.
module sbm_master #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_io,
  input wire logic cmd_lock,
  input wire logic cmd_fill,
  input wire logic cmd_all_bus,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [31:0] cmd_status,
  input wire logic user_stall,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [63:0] rd_data,
  output logic rd_cacheable,
  output logic rd_ownable,
  input wire logic grant,
  input wire logic group_transfer_acknowledge,
  input wire logic group_hold,
  input wire logic block_cacheable,
  input wire logic ownership_allowed,
  input wire logic transceiver_mode_select,
  input wire logic [63:0] system_addr_data_bus_in,
  output logic [63:0] system_addr_data_bus_out,
  output logic system_addr_data_bus_oe,
  output logic local_bus_request,
  output logic all_bus_request,
  output logic locked_sequence,
  output logic address_strobe,
  output logic hold_request,
  output logic transceiver_mode
);

  // Address field positions are fixed by the bus, so only 32 is served
  if (ADDR_W != 32) begin : g_bad_addr_w
    $error("ADDR_W must be 32");
  end

  sbm_pkg::sbm_state_t state;
  logic io_op;
  logic lock_op;
  logic ack_ok;
  logic mode_q;

  // ****************************************************************
  // Mode strap
  // ****************************************************************
  sbm_mode_latch u_mode (
    .clk(clk),
    .rst(rst),
    .transceiver_mode_select(transceiver_mode_select),
    .transceiver_mode(mode_q)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transceiver_mode <= 1'b0;
    end else begin
      transceiver_mode <= mode_q; // see [RQ9]
    end
  end

  // Group ack with group hold negated marks the qualifying clock
  assign ack_ok = group_transfer_acknowledge && !group_hold; // see [RQ10]

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // All handshakes launch and sample on the rising bus clock
  always_ff @(posedge clk or posedge rst) begin // see [RQ21]
    if (rst) begin
      state <= sbm_pkg::SBM_IDLE;
    end else begin
      unique case (state)
        sbm_pkg::SBM_IDLE: begin
          if (cmd_valid) begin
            // Re-grant: start address phase directly
            state <= grant ? sbm_pkg::SBM_ADDR
                           : sbm_pkg::SBM_ARB; // see [RQ1]
          end
        end
        sbm_pkg::SBM_ARB: begin
          if (grant) begin
            state <= sbm_pkg::SBM_ADDR;
          end
        end
        sbm_pkg::SBM_ADDR: begin
          state <= sbm_pkg::SBM_WAIT;
        end
        sbm_pkg::SBM_WAIT: begin
          if (ack_ok) begin
            state <= sbm_pkg::SBM_DATA;
          end
        end
        sbm_pkg::SBM_DATA: begin
          state <= sbm_pkg::SBM_GAP; // see [RQ10]
        end
        sbm_pkg::SBM_GAP: begin
          state <= sbm_pkg::SBM_IDLE; // see [RQ11]
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= (state == sbm_pkg::SBM_IDLE) && !cmd_valid;
    end
  end

  // ****************************************************************
  // Arbitration requests
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      local_bus_request <= 1'b0;
      all_bus_request <= 1'b0;
      io_op <= 1'b0;
      lock_op <= 1'b0;
    end else begin
      if (state == sbm_pkg::SBM_IDLE && cmd_valid) begin
        io_op <= cmd_io;
        lock_op <= cmd_lock && !cmd_fill; // see [RQ4]
        local_bus_request <= !grant; // see [RQ1]
        all_bus_request <= !grant && cmd_all_bus; // see [RQ5]
      end else if (grant) begin
        // Held without gaps until grant seen
        local_bus_request <= 1'b0; // see [RQ2]
        all_bus_request <= 1'b0; // see [RQ5]
      end
    end
  end

  // Lock stays up across back-to-back locked operations
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked_sequence <= 1'b0;
    end else if (state == sbm_pkg::SBM_IDLE && cmd_valid) begin
      locked_sequence <= cmd_lock && !cmd_fill; // see [RQ3] [RQ4]
    end else if (state == sbm_pkg::SBM_IDLE && !cmd_valid) begin
      locked_sequence <= 1'b0; // see [RQ3]
    end
  end

  // ****************************************************************
  // Address phase
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      address_strobe <= 1'b0;
      system_addr_data_bus_out <= 64'h0;
      system_addr_data_bus_oe <= 1'b0;
    end else begin
      address_strobe <= 1'b0;
      system_addr_data_bus_oe <= 1'b0; // see [RQ18]
      if ((state == sbm_pkg::SBM_IDLE && cmd_valid && grant) ||
          (state == sbm_pkg::SBM_ARB && grant)) begin
        address_strobe <= 1'b1; // see [RQ7]
        system_addr_data_bus_oe <= 1'b1;
        system_addr_data_bus_out <= 64'h0;
        system_addr_data_bus_out[`SBM_STATUS_MSB:`SBM_STATUS_LSB]
          <= cmd_status; // see [RQ6]
        if ((state == sbm_pkg::SBM_IDLE) ? cmd_io : io_op) begin
          system_addr_data_bus_out[`SBM_IO_ADDR_MSB:`SBM_IO_ADDR_LSB]
            <= cmd_addr[`SBM_IO_ADDR_MSB:`SBM_IO_ADDR_LSB]; // see [RQ6]
        end else begin
          system_addr_data_bus_out[`SBM_MEM_ADDR_MSB:`SBM_MEM_ADDR_LSB]
            <= cmd_addr[`SBM_MEM_ADDR_MSB:`SBM_MEM_ADDR_LSB]; // see [RQ6]
        end
      end
    end
  end

  // Never held while the strobe is up, nor after acknowledge drops;
  // once the qualifying clock has passed a hold would come too late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_request <= 1'b0;
    end else begin
      hold_request <= user_stall && (state == sbm_pkg::SBM_WAIT) &&
                      group_transfer_acknowledge &&
                      !ack_ok; // see [RQ19]
    end
  end

  // ****************************************************************
  // Read data capture
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= 64'h0;
      rd_cacheable <= 1'b0;
      rd_ownable <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state == sbm_pkg::SBM_WAIT && ack_ok) begin
        rd_cacheable <= block_cacheable;
        rd_ownable <= ownership_allowed;
      end
      if (state == sbm_pkg::SBM_DATA) begin
        rd_valid <= 1'b1; // see [RQ10]
        rd_data <= system_addr_data_bus_in;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_strobe;
    address_strobe;
  endsequence

  property p_strobe_one;
    @(posedge clk) disable iff (rst) s_strobe |=> !address_strobe;
  endproperty
  a_strobe_one: assert property (p_strobe_one) // see [RQ7]
    else $error("address strobe longer than one clock");

  property p_req_hold;
    @(posedge clk) disable iff (rst)
      local_bus_request && !grant |=> local_bus_request;
  endproperty
  a_req_hold: assert property (p_req_hold) // see [RQ2]
    else $error("local request dropped before grant");

  property p_all_hold;
    @(posedge clk) disable iff (rst)
      all_bus_request && !grant |=> all_bus_request;
  endproperty
  a_all_hold: assert property (p_all_hold) // see [RQ5]
    else $error("all-bus request dropped before grant");

  property p_regrant;
    @(posedge clk) disable iff (rst)
      state == sbm_pkg::SBM_IDLE && cmd_valid && grant
      |=> address_strobe && !local_bus_request;
  endproperty
  a_regrant: assert property (p_regrant) // see [RQ1]
    else $error("re-grant did not start at once");

  property p_no_drive_data;
    @(posedge clk) disable iff (rst)
      state == sbm_pkg::SBM_WAIT || state == sbm_pkg::SBM_DATA
      |-> !system_addr_data_bus_oe;
  endproperty
  a_no_drive_data: assert property (p_no_drive_data) // see [RQ18]
    else $error("bus driven in read data phase");

  sequence s_ack_ok;
    state == sbm_pkg::SBM_WAIT && ack_ok;
  endsequence

  property p_capture;
    @(posedge clk) disable iff (rst) s_ack_ok |=> ##1 rd_valid;
  endproperty
  a_capture: assert property (p_capture) // see [RQ10]
    else $error("data not captured one clock after acknowledge");

  property p_idle_gap;
    @(posedge clk) disable iff (rst)
      rd_valid |-> !address_strobe ##1 !address_strobe;
  endproperty
  a_idle_gap: assert property (p_idle_gap) // see [RQ11]
    else $error("no idle clock after read");

  property p_fill_unlocked;
    @(posedge clk) disable iff (rst)
      state == sbm_pkg::SBM_IDLE && cmd_valid && cmd_fill
      |=> !locked_sequence;
  endproperty
  a_fill_unlocked: assert property (p_fill_unlocked) // see [RQ4]
    else $error("fill raised locked sequence");

  property p_hold_strobe;
    @(posedge clk) disable iff (rst) address_strobe |-> !hold_request;
  endproperty
  a_hold_strobe: assert property (p_hold_strobe) // see [RQ19]
    else $error("hold request with strobe");

endmodule : sbm_master

// File: logic/sbm_mode_latch.sv
// Bus mode strap capture during reset
`timescale 1ns/1ps
module sbm_mode_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic transceiver_mode_select,
  output logic transceiver_mode
);
  // Strap sampled by clock while reset holds, never as reset value
  always_ff @(posedge clk) begin
    if (rst) begin
      transceiver_mode <= transceiver_mode_select; // see [RQ9]
    end
  end
endmodule : sbm_mode_latch

// File: logic/sbm_pkg.sv
// Types for the system bus master read port
package sbm_pkg;
  typedef enum logic [2:0] {
    SBM_IDLE,
    SBM_ARB,
    SBM_ADDR,
    SBM_WAIT,
    SBM_DATA,
    SBM_GAP
  } sbm_state_t;
endpackage : sbm_pkg

// File: logic/sbm_regs.svh
// Constants for the system bus master read port
`ifndef SBM_REGS_SVH
`define SBM_REGS_SVH
`define SBM_CLK_PERIOD_NS 10
`define SBM_IDLE_MIN_NS 10
`define SBM_IDLE_CYCLES ((`SBM_IDLE_MIN_NS + `SBM_CLK_PERIOD_NS - 1) / `SBM_CLK_PERIOD_NS)
`define SBM_MEM_ADDR_LSB 3
`define SBM_MEM_ADDR_MSB 31
`define SBM_IO_ADDR_LSB 2
`define SBM_IO_ADDR_MSB 15
`define SBM_STATUS_LSB 32
`define SBM_STATUS_MSB 63
`endif

// File: tb/sbm_far_model.sv
// Arbiter, group logic and slave model facing the bus master read port
`timescale 1ns/1ps
module sbm_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic local_bus_request,
  input wire logic all_bus_request,
  input wire logic address_strobe,
  input wire logic hold_request,
  input wire logic fast_grant,
  input wire logic [1:0] ack_dly,
  input wire logic [1:0] hold_len,
  input wire logic cach,
  input wire logic own_v,
  input wire logic [63:0] data,
  output logic grant,
  output logic group_transfer_acknowledge,
  output logic group_hold,
  output logic block_cacheable,
  output logic ownership_allowed,
  output logic [63:0] bus_in
);
  logic req_seen;
  logic slave_hold;
  // Grant one clock after a request, unless parked on the master
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      req_seen <= 1'b0;
    end else begin
      req_seen <= local_bus_request | all_bus_request;
    end
  end
  assign grant = fast_grant | req_seen;
  assign group_hold = slave_hold | hold_request;
  initial begin
    group_transfer_acknowledge = 1'b0;
    slave_hold = 1'b0;
    block_cacheable = 1'b0;
    ownership_allowed = 1'b0;
    bus_in = 64'h0;
    forever begin
      @(negedge clk);
      if (address_strobe && !rst) begin
        repeat (ack_dly) @(posedge clk);
        #1;
        group_transfer_acknowledge = 1'b1;
        block_cacheable = cach;
        ownership_allowed = own_v;
        slave_hold = (hold_len != 2'h0);
        repeat (hold_len) @(posedge clk);
        #1;
        slave_hold = 1'b0;
        @(negedge clk);
        while (group_hold) @(negedge clk);
        @(posedge clk);
        #1;
        group_transfer_acknowledge = 1'b0;
        block_cacheable = 1'b0;
        bus_in = data;
        @(posedge clk);
        #1;
        // Released bus shows no stale data
        bus_in = ~data;
      end
    end
  end
endmodule : sbm_far_model

// File: tb/tb.sv
// Self-checking bench for the system bus master read port
`timescale 1ns/1ps
module tb;
  logic clk, rst, cmd_valid, cmd_io, cmd_lock, cmd_fill, cmd_all_bus;
  logic [31:0] cmd_addr, cmd_status;
  logic user_stall, cmd_ready, rd_valid, rd_cacheable, rd_ownable, grant;
  logic [63:0] rd_data, system_addr_data_bus_in, system_addr_data_bus_out;
  logic group_transfer_acknowledge, group_hold, block_cacheable;
  logic ownership_allowed, transceiver_mode_select, system_addr_data_bus_oe;
  logic local_bus_request, all_bus_request, locked_sequence;
  logic address_strobe, hold_request, transceiver_mode;
  logic fast_grant, cach, own_v;
  logic [1:0] ack_dly, hold_len;
  logic [63:0] data;
  logic [65:0] exp_q[$];
  logic [65:0] e;
  logic [31:0] r;
  int seed = 32'hA39FC346;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int last_rv = 0;
  sbm_master dut (.clk, .rst, .cmd_valid, .cmd_io, .cmd_lock, .cmd_fill,
    .cmd_all_bus, .cmd_addr, .cmd_status, .user_stall, .cmd_ready,
    .rd_valid, .rd_data, .rd_cacheable, .rd_ownable, .grant,
    .group_transfer_acknowledge, .group_hold, .block_cacheable,
    .ownership_allowed, .transceiver_mode_select, .system_addr_data_bus_in,
    .system_addr_data_bus_out, .system_addr_data_bus_oe, .local_bus_request,
    .all_bus_request, .locked_sequence, .address_strobe, .hold_request,
    .transceiver_mode);
  sbm_far_model far (.clk, .rst, .local_bus_request, .all_bus_request,
    .address_strobe, .hold_request, .fast_grant, .ack_dly, .hold_len, .cach,
    .own_v, .data, .grant, .group_transfer_acknowledge, .group_hold,
    .block_cacheable, .ownership_allowed, .bus_in(system_addr_data_bus_in));
  // ****************************************************
  // Checking helpers and read driver
  // ****************************************************
  task automatic chk(input string nm, input logic [63:0] x,
                     input logic [63:0] s);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic reset_run(input logic m);
    rst = 1'b1;
    transceiver_mode_select = m;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
    chk("transceiver_mode", m, transceiver_mode);
    $display("reset test done");
  endtask : reset_run
  task automatic rd(input logic io, lk, fl, al, fast, input logic [1:0] ad, hl,
                    input logic st);
    logic [63:0] d;
    logic seen;
    int n;
    d = {$random(seed), $random(seed)};
    seen = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    {cmd_io, cmd_lock, cmd_fill, cmd_all_bus} = {io, lk, fl, al};
    cmd_addr = $random(seed);
    cmd_status = $random(seed);
    {fast_grant, ack_dly, hold_len, user_stall} = {fast, ad, hl, st};
    {data, cach, own_v} = {d, !io & d[0], d[1]};
    exp_q.push_back({d, !io & d[0], d[1]});
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    n = 0;
    @(negedge clk);
    while (address_strobe !== 1'b1 && n < 20) begin
      chk("local_bus_request", 1, local_bus_request);
      chk("all_bus_request", al, all_bus_request);
      chk("locked_sequence", lk & !fl, locked_sequence);
      @(negedge clk);
      n++;
    end
    chk("grant_wait", fast ? 0 : 2, n);
    chk("idle_gap", 1, cyc > last_rv);
    chk("bus_oe", 1, system_addr_data_bus_oe);
    if (io)
      chk("io_addr", cmd_addr[15:2],
          system_addr_data_bus_out[15:2]);
    else
      chk("mem_addr", cmd_addr[31:3],
          system_addr_data_bus_out[31:3]);
    chk("status", cmd_status, system_addr_data_bus_out[63:32]);
    n = 0;
    @(negedge clk);
    chk("strobe_len", 0, address_strobe);
    while (rd_valid !== 1'b1 && n < 30) begin
      chk("bus_oe", 0, system_addr_data_bus_oe);
      if (user_stall && hold_request === 1'b1) begin
        seen = 1'b1;
        @(posedge clk);
        #1 user_stall = 1'b0;
      end
      @(negedge clk);
      n++;
    end
    chk("hold_request", st, seen);
    chk("rd_valid", 1, rd_valid);
    last_rv = cyc;
    @(posedge clk);
    #1;
  endtask : rd
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("expected_queue", 1, 0);
      end else begin
        e = exp_q.pop_front();
        chk("rd_data", e[65:2], rd_data);
        chk("rd_cacheable", e[1], rd_cacheable);
        chk("rd_ownable", e[0], rd_ownable);
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    {rst, cmd_valid, cmd_io, cmd_lock, cmd_fill, cmd_all_bus} = 6'h20;
    {cmd_addr, cmd_status, user_stall, transceiver_mode_select} = 66'h0;
    {fast_grant, cach, own_v, ack_dly, hold_len, data} = 71'h0;
    reset_run(1'b1);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      // A stall needs a slave wait so the master can hold before data
      rd(i[0], i[1], i[2], i[3], r[0], {1'b1, r[1]},
         {r[3], r[2] | (i == 5)}, i == 5);
      $display("read test %0d done", i);
    end
    reset_run(1'b0);
    rd(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h3, 2'h1, 1'b1);
    $display("read after reset done");
    wrap_up();
  end
endmodule : tb
